// ---- design/dmau_pkg.sv ----
// constants and types of the data-memory address unit
package dmau_pkg;
  // ------------------------------------------------------------
  // address geometry
  // ------------------------------------------------------------
  localparam int          ADDR_W       = 12;
  localparam int          DATA_W       = 8;
  localparam int          MEM_DEPTH    = 4096;
  localparam int          NUM_PTR      = 3;
  localparam int          NUM_BANKS    = 16;
  localparam logic [7:0]  LOW_WIN_END  = 8'h60;
  localparam logic [3:0]  LOW_WIN_BANK = 4'h0;
  localparam logic [3:0]  SFR_BANK     = 4'hF;
  localparam logic [15:0] BANK_IMPL    = 16'h80FF;
  localparam logic [11:0] VOP0_ADDR    = 12'hFE8;
  localparam logic [11:0] VOP1_ADDR    = 12'hFE9;
  localparam logic [11:0] VOP2_ADDR    = 12'hFEA;
  // ------------------------------------------------------------
  // register map and reset values
  // ------------------------------------------------------------
  localparam logic [7:0]  BSR_OFS      = 8'h00;
  localparam logic [7:0]  PTR0_OFS     = 8'h04;
  localparam logic [7:0]  PTR1_OFS     = 8'h08;
  localparam logic [7:0]  PTR2_OFS     = 8'h0C;
  localparam logic [7:0]  STAT_OFS     = 8'h10;
  localparam logic [3:0]  BSR_RST      = 4'h0;
  localparam logic [11:0] PTR_RST      = 12'h000;
  localparam int          STAT_NULL_B  = 16;
  localparam int          STAT_UNIMP_B = 17;
  localparam int          STAT_VOP_B   = 18;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;
  // ------------------------------------------------------------
  // core operations
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_DIRECT,
    OP_MOVE,
    OP_LOAD_BANK,
    OP_LOAD_PTR
  } dmau_op_e;
endpackage

// ---- design/dmau_addr_form.sv ----
// direct operand address former: bank window or fast access window
`timescale 1ns/100ps
module dmau_addr_form (
  // instruction fields
  input  wire logic        access_bit,
  input  wire logic [7:0]  operand,
  // bank selection
  input  wire logic [3:0]  bank_sel,
  // formed address
  output logic      [11:0] addr
);
  always_comb begin
    if (access_bit) begin
      addr = {bank_sel, operand};
    end else if (operand < dmau_pkg::LOW_WIN_END) begin
      addr = {dmau_pkg::LOW_WIN_BANK, operand};
    end else begin
      // high part lands on the register bank, no bank switch needed
      addr = {dmau_pkg::SFR_BANK, operand};
    end
  end
endmodule

// ---- design/dmau_ptr_reg.sv ----
// one 12-bit indirect pointer built from a low byte and a high nibble
`timescale 1ns/100ps
module dmau_ptr_reg (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // core load
  input  wire logic        core_ld,
  input  wire logic [11:0] core_val,
  // bus load with byte lanes
  input  wire logic        bus_ld,
  input  wire logic [1:0]  bus_strb,
  input  wire logic [15:0] bus_val,
  // pointer value
  output logic      [11:0] ptr_q
);
  logic [11:0] ptr_d;

  // the core wins a same-cycle collision: its instruction stream owns it
  always_comb begin
    ptr_d = ptr_q;
    if (core_ld) begin
      ptr_d = core_val;
    end else if (bus_ld) begin
      if (bus_strb[0]) begin
        ptr_d[7:0] = bus_val[7:0];
      end
      if (bus_strb[1]) begin
        ptr_d[11:8] = bus_val[11:8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_q <= dmau_pkg::PTR_RST;
    end else begin
      ptr_q <= ptr_d;
    end
  end
endmodule

// ---- design/dmau_top.sv ----
// data-memory address unit: bank, access window and indirect pointers
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/100ps
module dmau_top (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address and data
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // core request
  input  wire logic              core_req,
  input  wire dmau_pkg::dmau_op_e core_op,
  input  wire logic              core_access,
  input  wire logic [7:0]        core_operand,
  input  wire logic [11:0]       core_full_addr,
  input  wire logic [11:0]       core_literal,
  input  wire logic [1:0]        core_ptr_sel,
  input  wire logic              core_we,
  input  wire logic [7:0]        core_wdata,
  // core answer
  output logic                   core_rvalid,
  output logic [7:0]             core_rdata,
  output logic [11:0]            core_eff_addr,
  output logic                   core_null
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [3:0]  bsr_q, bsr_d;
  logic [11:0] ptr_q [dmau_pkg::NUM_PTR];
  logic [7:0]  mem_q [dmau_pkg::MEM_DEPTH];
  logic        rvalid_q, rvalid_d;
  logic [7:0]  rdata_q, rdata_d;
  logic [11:0] eff_q, eff_d;
  logic        null_q, null_d;
  logic        unimp_q, unimp_d;
  logic        vop_q, vop_d;

  // ------------------------------------------------------------
  // address formation
  // ------------------------------------------------------------
  logic [11:0] direct_addr;
  logic [11:0] sel_addr;
  logic [11:0] target;
  logic        vop_hit;
  logic [1:0]  vop_idx;
  logic        tgt_is_vop;
  logic        bank_ok;
  logic        access_null;
  logic        mem_op;
  logic        mem_we;

  dmau_addr_form u_addr_form (
    .access_bit (core_access),
    .operand    (core_operand),
    .bank_sel   (bsr_q),
    .addr       (direct_addr)
  );

  function automatic logic is_vop(input logic [11:0] a);
    is_vop = (a == dmau_pkg::VOP0_ADDR) || (a == dmau_pkg::VOP1_ADDR) ||
             (a == dmau_pkg::VOP2_ADDR);
  endfunction

  always_comb begin
    mem_op  = (core_op == dmau_pkg::OP_DIRECT) ||
              (core_op == dmau_pkg::OP_MOVE);
    // the access bit decides inside the former; a move bypasses it
    sel_addr = (core_op == dmau_pkg::OP_MOVE) ? core_full_addr
                                              : direct_addr;
    vop_hit = is_vop(sel_addr);
    vop_idx = 2'd0;
    if (sel_addr == dmau_pkg::VOP1_ADDR) begin
      vop_idx = 2'd1;
    end else if (sel_addr == dmau_pkg::VOP2_ADDR) begin
      vop_idx = 2'd2;
    end
    target      = vop_hit ? ptr_q[vop_idx] : sel_addr;
    tgt_is_vop  = vop_hit && is_vop(target);
    bank_ok     = dmau_pkg::BANK_IMPL[target[11:8]];
    access_null = tgt_is_vop || !bank_ok;
    mem_we      = core_req && mem_op && core_we && !access_null;
  end

  // ------------------------------------------------------------
  // data memory
  // ------------------------------------------------------------
  // only implemented banks are ever written; the array still holds storage for all MEM_DEPTH entries
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      mem_q[target] <= core_wdata;
    end
  end

  // ------------------------------------------------------------
  // core answer
  // ------------------------------------------------------------
  always_comb begin
    rvalid_d = core_req && mem_op;
    rdata_d  = rdata_q;
    eff_d    = eff_q;
    null_d   = null_q;
    unimp_d  = unimp_q;
    vop_d    = vop_q;
    if (core_req && mem_op) begin
      rdata_d = access_null ? 8'h00 : mem_q[target];
      eff_d   = target;
      null_d  = access_null;
      unimp_d = !bank_ok;
      vop_d   = tgt_is_vop;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 8'h00;
      eff_q    <= 12'h000;
      null_q   <= 1'b0;
      unimp_q  <= 1'b0;
      vop_q    <= 1'b0;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      eff_q    <= eff_d;
      null_q   <= null_d;
      unimp_q  <= unimp_d;
      vop_q    <= vop_d;
    end
  end

  assign core_rvalid   = rvalid_q;
  assign core_rdata    = rdata_q;
  assign core_eff_addr = eff_q;
  assign core_null     = null_q;

  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------
  logic        aw_full_q, aw_full_d;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic        w_full_q, w_full_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0]  w_strb_q, w_strb_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        arvalid_q, arvalid_d;
  logic [31:0] ardata_q, ardata_d;
  logic [1:0]  arresp_q, arresp_d;
  logic        bus_wr;
  logic        bsr_wr;
  logic [2:0]  ptr_wr;
  logic [31:0] rd_word;
  logic        rd_ok;

  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready  = !w_full_q;
  assign s_axi_arready = !arvalid_q;
  assign bus_wr        = aw_full_q && w_full_q && !bvalid_q;

  always_comb begin
    bsr_wr = 1'b0;
    ptr_wr = 3'b000;
    if (aw_addr_q == dmau_pkg::BSR_OFS) begin
      bsr_wr = bus_wr;
    end else if (aw_addr_q == dmau_pkg::PTR0_OFS) begin
      ptr_wr[0] = bus_wr;
    end else if (aw_addr_q == dmau_pkg::PTR1_OFS) begin
      ptr_wr[1] = bus_wr;
    end else if (aw_addr_q == dmau_pkg::PTR2_OFS) begin
      ptr_wr[2] = bus_wr;
    end
  end

  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == dmau_pkg::BSR_OFS) begin
      rd_word = {28'h000_0000, bsr_q};
    end else if (s_axi_araddr == dmau_pkg::PTR0_OFS) begin
      rd_word = {20'h0_0000, ptr_q[0]};
    end else if (s_axi_araddr == dmau_pkg::PTR1_OFS) begin
      rd_word = {20'h0_0000, ptr_q[1]};
    end else if (s_axi_araddr == dmau_pkg::PTR2_OFS) begin
      rd_word = {20'h0_0000, ptr_q[2]};
    end else if (s_axi_araddr == dmau_pkg::STAT_OFS) begin
      rd_word = {13'h0000, vop_q, unimp_q, null_q, 4'h0, eff_q};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_comb begin
    aw_full_d = aw_full_q;
    aw_addr_d = aw_addr_q;
    w_full_d  = w_full_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    arvalid_d = arvalid_q;
    ardata_d  = ardata_q;
    arresp_d  = arresp_q;
    if (s_axi_awvalid && !aw_full_q) begin
      aw_full_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full_q) begin
      w_full_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (bus_wr) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (bsr_wr || (ptr_wr != 3'b000)) ? dmau_pkg::RESP_OKAY
                                                 : dmau_pkg::RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !arvalid_q) begin
      arvalid_d = 1'b1;
      ardata_d  = rd_word;
      arresp_d  = rd_ok ? dmau_pkg::RESP_OKAY : dmau_pkg::RESP_SLVERR;
    end else if (arvalid_q && s_axi_rready) begin
      arvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_full_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= dmau_pkg::RESP_OKAY;
      arvalid_q <= 1'b0;
      ardata_q  <= 32'h0000_0000;
      arresp_q  <= dmau_pkg::RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      aw_addr_q <= aw_addr_d;
      w_full_q  <= w_full_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arvalid_q <= arvalid_d;
      ardata_q  <= ardata_d;
      arresp_q  <= arresp_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = arvalid_q;
  assign s_axi_rdata  = ardata_q;
  assign s_axi_rresp  = arresp_q;

  // ------------------------------------------------------------
  // bank select register and pointers
  // ------------------------------------------------------------
  logic core_bank_ld;

  assign core_bank_ld = core_req && (core_op == dmau_pkg::OP_LOAD_BANK);

  // core load wins over a bus write in the same cycle
  always_comb begin
    bsr_d = bsr_q;
    if (core_bank_ld) begin
      bsr_d = core_literal[3:0];
    end else if (bsr_wr && w_strb_q[0]) begin
      bsr_d = w_data_q[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bsr_q <= dmau_pkg::BSR_RST;
    end else begin
      bsr_q <= bsr_d;
    end
  end

  for (genvar i = 0; i < dmau_pkg::NUM_PTR; i++) begin : g_ptr
    dmau_ptr_reg u_ptr (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .core_ld  (core_req && (core_op == dmau_pkg::OP_LOAD_PTR) &&
                 (core_ptr_sel == 2'(i))),
      .core_val (core_literal),
      .bus_ld   (ptr_wr[i]),
      .bus_strb (w_strb_q[1:0]),
      .bus_val  (w_data_q[15:0]),
      .ptr_q    (ptr_q[i])
    );
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic dir_req;
  assign dir_req = core_req && (core_op == dmau_pkg::OP_DIRECT) && !vop_hit;

  win_low_a: assert property (dir_req && !core_access &&
      core_operand < dmau_pkg::LOW_WIN_END |=>
      core_eff_addr == {4'h0, $past(core_operand)})
    else $error("low window address wrong");
  win_high_a: assert property (dir_req && !core_access &&
      core_operand >= dmau_pkg::LOW_WIN_END |=>
      core_eff_addr == {4'hF, $past(core_operand)})
    else $error("high window address wrong");
  bank_addr_a: assert property (dir_req && core_access |=>
      core_eff_addr == {$past(bsr_q), $past(core_operand)})
    else $error("banked address wrong");
  move_addr_a: assert property (core_req && !vop_hit &&
      core_op == dmau_pkg::OP_MOVE |=> core_eff_addr == $past(core_full_addr))
    else $error("move address wrong");
  unimp_zero_a: assert property (core_req && mem_op && !bank_ok |=>
      core_rvalid && core_rdata == 8'h00 && core_null)
    else $error("unimplemented bank not zero");
  ind_addr_a: assert property (core_req && mem_op && vop_hit |=>
      core_rvalid && core_eff_addr == $past(ptr_q[sel_addr[1:0]]))
    else $error("indirect access misrouted");
  vop_read_a: assert property (core_req && mem_op && tgt_is_vop |=>
      core_rdata == 8'h00 && core_null)
    else $error("virtual operand read not zero");
  vop_write_a: assert property (core_req && core_we && tgt_is_vop |->
      !mem_we)
    else $error("virtual operand write reached memory");
  bank_load_a: assert property (core_bank_ld |=>
      bsr_q == $past(core_literal[3:0]) ##1 bsr_q == $past(bsr_q) ||
      $past(core_bank_ld) || $past(bsr_wr))
    else $error("bank load lost");
  bsr_read_a: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == dmau_pkg::BSR_OFS |=> s_axi_rdata[31:4] == 28'h0)
    else $error("bank select upper bits not zero");

  win_hi_c: cover property (dir_req && !core_access &&
      core_operand == dmau_pkg::LOW_WIN_END);
  ind_c: cover property (core_req && mem_op && vop_hit && !tgt_is_vop);
  unimp_c: cover property (core_req && mem_op && !bank_ok);
  axi_wr_c: cover property (bsr_wr ##[1:4] s_axi_bvalid && s_axi_bready);
endmodule

// ---- testbench/dmau_core_model.sv ----
// partner model of the core decoder that issues requests to the unit
`timescale 1ns/100ps
module dmau_core_model (
  // clock
  input  wire logic          aclk,
  // core request
  output logic               core_req,
  output dmau_pkg::dmau_op_e core_op,
  output logic               core_access,
  output logic [7:0]         core_operand,
  output logic [11:0]        core_full_addr,
  output logic [11:0]        core_literal,
  output logic [1:0]         core_ptr_sel,
  output logic               core_we,
  output logic [7:0]         core_wdata
);
  initial begin
    core_req       = 1'b0;
    core_op        = dmau_pkg::OP_DIRECT;
    core_access    = 1'b0;
    core_operand   = 8'h00;
    core_full_addr = 12'h000;
    core_literal   = 12'h000;
    core_ptr_sel   = 2'b11;
    core_we        = 1'b0;
    core_wdata     = 8'h00;
  end
  // every call is one request; calls follow each other back to back
  task automatic issue(input dmau_pkg::dmau_op_e op, input logic ac,
                       input logic [7:0] opd, input logic [11:0] fa,
                       input logic [11:0] lit, input logic [1:0] sel,
                       input logic we, input logic [7:0] wd);
    @(posedge aclk);
    core_req       <= 1'b1;
    core_op        <= op;
    core_access    <= ac;
    core_operand   <= opd;
    core_full_addr <= fa;
    core_literal   <= lit;
    core_ptr_sel   <= sel;
    core_we        <= we;
    core_wdata     <= wd;
  endtask
  // an idle core leaves no stale operand behind
  task automatic idle();
    @(posedge aclk);
    core_req     <= 1'b0;
    core_operand <= ~core_operand;
  endtask
endmodule

// ---- testbench/tb_top.sv ----
// self-checking bench of the data-memory address unit
`timescale 1ns/100ps
module tb_top;
  typedef struct {
    logic [7:0]  d;
    logic [11:0] a;
    logic        n;
    logic        cd;
    logic        ca;
  } dmau_exp_s;
  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        core_req, core_access, core_we, core_rvalid, core_null;
  dmau_pkg::dmau_op_e core_op;
  logic [7:0]  core_operand, core_wdata, core_rdata, r;
  logic [11:0] core_full_addr, core_literal, core_eff_addr;
  logic [1:0]  core_ptr_sel;
  int          num_errors, n_tests, i;
  logic [3:0]  bank_m;
  logic [11:0] ptr_m [3];
  logic [7:0]  mem_m [4096];
  logic [7:0]  wo [5] = '{8'h00, 8'h5f, 8'h60, 8'h9c, 8'hff};
  dmau_exp_s   cq [$];
  dmau_exp_s   e;
  logic [31:0] rq [$];
  logic [1:0]  bq [$];
  logic [1:0]  rrq [$];

  dmau_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_req, .core_op,
    .core_access, .core_operand, .core_full_addr, .core_literal,
    .core_ptr_sel, .core_we, .core_wdata, .core_rvalid, .core_rdata,
    .core_eff_addr, .core_null);
  dmau_core_model u_core (.aclk, .core_req, .core_op, .core_access,
    .core_operand, .core_full_addr, .core_literal, .core_ptr_sel,
    .core_we, .core_wdata);

  initial aclk = 1'b0;
  always #2.5 aclk = ~aclk;
  // ------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_edge(inout int n);
    @(posedge aclk);
    n++;
    if (n > 200) begin
      num_errors++;
      $display("CHECK FAILED %0t wait ran out", $time);
      report_and_stop();
    end
  endtask
  // ------------------------------------------------------------
  // axi4-lite master
  // ------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] rs);
    int   n;
    logic ad;
    logic wd;
    n  = 0;
    ad = 1'b0;
    wd = 1'b0;
    bq.push_back(rs);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(ad && wd)) begin
      wait_edge(n);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) wait_edge(n);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] rs);
    int n;
    n = 0;
    rq.push_back(d);
    rrq.push_back(rs);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do wait_edge(n); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) wait_edge(n);
    s_axi_rready <= 1'b0;
  endtask
  // ------------------------------------------------------------
  // core requests with expected answers worked out alongside
  // ------------------------------------------------------------
  task automatic acc(input logic mv, input logic ac, input logic [11:0] a,
                     input logic we, input logic [7:0] wd);
    dmau_exp_s x;
    logic [11:0] t;
    if (mv) t = a;
    else if (ac) t = {bank_m, a[7:0]};
    else if (a[7:0] < dmau_pkg::LOW_WIN_END) t = {4'h0, a[7:0]};
    else t = {4'hf, a[7:0]};
    x.n  = 1'b0;
    x.ca = 1'b1;
    x.cd = !we;
    if (t >= dmau_pkg::VOP0_ADDR && t <= dmau_pkg::VOP2_ADDR) begin
      t = ptr_m[t - dmau_pkg::VOP0_ADDR];
      if (t >= dmau_pkg::VOP0_ADDR && t <= dmau_pkg::VOP2_ADDR) begin
        x.n  = 1'b1;
        x.ca = 1'b0;
      end
    end
    if (!dmau_pkg::BANK_IMPL[t[11:8]]) x.n = 1'b1;
    x.a = t;
    x.d = x.n ? 8'h00 : mem_m[t];
    if (we && !x.n) mem_m[t] = wd;
    cq.push_back(x);
    u_core.issue(mv ? dmau_pkg::OP_MOVE : dmau_pkg::OP_DIRECT, ac,
                 a[7:0], a, 12'h000, 2'b11, we, wd);
  endtask
  task automatic load(input logic bk, input logic [1:0] sel,
                      input logic [11:0] v);
    if (bk) bank_m = v[3:0];
    else ptr_m[sel] = v;
    u_core.issue(bk ? dmau_pkg::OP_LOAD_BANK : dmau_pkg::OP_LOAD_PTR,
                 1'b0, 8'h00, 12'h000, v, sel, 1'b0, 8'h00);
  endtask
  // ------------------------------------------------------------
  // result watcher
  // ------------------------------------------------------------
  always @(posedge aclk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      check(32'(s_axi_bresp), 32'(bq.pop_front()));
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      check(s_axi_rdata, rq.pop_front());
      check(32'(s_axi_rresp), 32'(rrq.pop_front()));
    end
    if (core_rvalid === 1'b1) begin
      e = cq.pop_front();
      if (e.cd) check(32'(core_rdata), 32'(e.d));
      if (e.ca) check(32'(core_eff_addr), 32'(e.a));
      check(32'(core_null), 32'(e.n));
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    num_errors = 0;
    n_tests    = 0;
    bank_m     = 4'h0;
    ptr_m      = '{default: 12'h000};
    void'($urandom(44));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(dmau_pkg::BSR_OFS, 32'h0000_0000, dmau_pkg::RESP_OKAY);
    for (i = 0; i < 3; i++)
      axi_rd(dmau_pkg::PTR0_OFS + 8'(4 * i), 32'h0000_0000,
             dmau_pkg::RESP_OKAY);
    axi_rd(8'h14, 32'h0000_0000, dmau_pkg::RESP_SLVERR);
    axi_wr(8'h20, 32'hffff_ffff, 4'hf, dmau_pkg::RESP_SLVERR);
    // upper nibble of the bank select must not stick
    axi_wr(dmau_pkg::BSR_OFS, 32'h0000_00f7, 4'h1, dmau_pkg::RESP_OKAY);
    bank_m = 4'h7;
    axi_rd(dmau_pkg::BSR_OFS, 32'h0000_0007, dmau_pkg::RESP_OKAY);
    $display("test registers done");
    foreach (wo[k]) acc(1'b0, 1'b0, {4'h0, wo[k]}, 1'b1, 8'($urandom));
    foreach (wo[k]) acc(1'b0, 1'b0, {4'h0, wo[k]}, 1'b0, 8'h00);
    $display("test access window done");
    // a bank load is used by the very next request
    for (i = 0; i < 4; i++) begin
      r = 8'($urandom);
      load(1'b1, 2'b00, 12'(2 * i + 1));
      acc(1'b0, 1'b1, {4'h0, r}, 1'b1, 8'($urandom));
      acc(1'b0, 1'b1, {4'h0, r}, 1'b0, 8'h00);
    end
    load(1'b1, 2'b00, 12'h009);
    acc(1'b0, 1'b1, 12'h010, 1'b1, 8'h5a);
    acc(1'b0, 1'b1, 12'h010, 1'b0, 8'h00);
    u_core.idle();
    axi_rd(dmau_pkg::STAT_OFS, 32'h0003_0910, dmau_pkg::RESP_OKAY);
    acc(1'b1, 1'b0, 12'h7a5, 1'b1, 8'h3c);
    acc(1'b1, 1'b0, 12'h7a5, 1'b0, 8'h00);
    $display("test banks and move done");
    load(1'b0, 2'b00, 12'h123);
    load(1'b0, 2'b10, 12'h7a5);
    u_core.idle();
    axi_wr(dmau_pkg::PTR1_OFS, 32'h0000_0abc, 4'h1, dmau_pkg::RESP_OKAY);
    axi_wr(dmau_pkg::PTR1_OFS, 32'h0000_0533, 4'h2, dmau_pkg::RESP_OKAY);
    ptr_m[1] = 12'h5bc;
    axi_rd(dmau_pkg::PTR1_OFS, 32'h0000_05bc, dmau_pkg::RESP_OKAY);
    axi_rd(dmau_pkg::PTR0_OFS, 32'h0000_0123, dmau_pkg::RESP_OKAY);
    for (i = 0; i < 3; i++) begin
      acc(1'b0, 1'b0, 12'h0e8 + 12'(i), 1'b1, 8'($urandom));
      acc(1'b0, 1'b0, 12'h0e8 + 12'(i), 1'b0, 8'h00);
    end
    acc(1'b1, 1'b0, 12'h7a5, 1'b0, 8'h00);
    // a pointer aimed at a virtual operand reads zero and writes nothing
    load(1'b0, 2'b00, 12'hfea);
    acc(1'b0, 1'b0, 12'h0e8, 1'b1, 8'ha5);
    acc(1'b0, 1'b0, 12'h0e8, 1'b0, 8'h00);
    acc(1'b1, 1'b0, 12'h7a5, 1'b0, 8'h00);
    u_core.idle();
    axi_rd(dmau_pkg::PTR0_OFS, 32'h0000_0fea, dmau_pkg::RESP_OKAY);
    axi_rd(dmau_pkg::STAT_OFS, 32'h0000_07a5, dmau_pkg::RESP_OKAY);
    $display("test pointers done");
    repeat (4) @(posedge aclk);
    check(32'(cq.size()), 32'h0000_0000);
    report_and_stop();
  end
endmodule
